// file: common/io_port_pkg.sv
// Notes on behaviour
// - ports A/B mode bit 0 gives plain host I/O, 1 gives latched address out.
// - bit n of every port register acts on pin n of that port.
// - mode, direction and drive-select registers are 00h after reset.
// - direction bit 1 makes an output, 0 an input; all pins start as inputs.
// - ports A-C drive when direction bit or logic-array enable term is active; in data port mode port A drives only when dataPortDrive is set.
// - only the low three direction bits of port D act.
// - drive bit 1 on open-drain pins gives open drain; 0 gives push-pull.
// - drive bit 1 on slew pins selects fast slew; default slow.
// - ports A/B drive bits 7-4 set open drain, bits 3-0 set slew.
// - port C drive bits all open drain; port D bits 2-0 slew only.
// - input-sample read returns pin levels of that port.
// - output value register reads back; drives pins only where enabled.
// - ports A-C output-cell read returns cells; write loads unmasked bits.
// - load-mask bit 1 blocks host loading of that cell; resets to 0.
// - input cells capture pins, feed logic-array bus, host-readable.
// - ports A-C drive-status read shows 1 for driving pin, 0 for tri-stated input; port D reads 00h.
// - chip-select input on port D pin 2 high disables memories and registers.
// - three chip-select outputs on port D, each term with selectable polarity.
// - ports C and D have no mode register; those offsets are not decoded.
// - cell group one goes to port A or B, group two to port B or C.
// - port A carries host data bits 7-0 in non-multiplexed 8-bit mode.
`default_nettype none
package io_port_pkg;
	localparam int PORT_W = 8;
	localparam int PORT_D_PINS = 3;
	// register offsets, port a at base, ports spaced by PORT_STEP
	localparam logic [7:0] OFS_INPUT_SAMPLE = 8'h00;
	localparam logic [7:0] OFS_MODE_SELECT = 8'h02;
	localparam logic [7:0] OFS_OUTPUT_VALUE = 8'h04;
	localparam logic [7:0] OFS_DIRECTION = 8'h06;
	localparam logic [7:0] OFS_DRIVE_SELECT = 8'h08;
	localparam logic [7:0] OFS_INPUT_CELL = 8'h0A;
	localparam logic [7:0] OFS_CELL_VALUE = 8'h20;
	localparam logic [7:0] OFS_CELL_MASK = 8'h22;
	localparam logic [7:0] OFS_DRIVE_STATUS = 8'h0C;
	localparam logic [7:0] PORT_STEP = 8'h01;
	localparam logic [7:0] RESET_CFG = 8'h00;
	localparam logic [7:0] OPEN_DRAIN_AB = 8'hF0;
	localparam logic [7:0] SLEW_AB = 8'h0F;
	localparam logic [7:0] OPEN_DRAIN_C = 8'hFF;
	localparam logic [7:0] SLEW_D = 8'h07;
	localparam logic [7:0] PORT_D_MASK = 8'h07;
	localparam int CS_IN_BIT = 2;
	typedef enum logic [1:0] {
		PORT_A = 2'h0,
		PORT_B = 2'h1,
		PORT_C = 2'h2,
		PORT_D = 2'h3
	} port_sel_t;
	typedef struct packed {
		logic       rd;
		logic       wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} host_req_t;
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oen;
		logic [7:0] fast;
	} pin_drive_t;
endpackage : io_port_pkg
`default_nettype wire

// file: verilog/pin_sync.sv
`default_nettype none
module pin_sync #(
	parameter int W = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         resetn,
	// raw and synchronised levels
	input  wire logic [W-1:0] raw,
	output var  logic [W-1:0] sync
);
	logic [W-1:0] stage1;
	always_ff @(posedge clk) begin
		if (!resetn) begin
			stage1 <= '0;
			sync   <= '0;
		end else begin
			stage1 <= raw;
			sync   <= stage1;
		end
	end
endmodule : pin_sync
`default_nettype wire

// file: verilog/configurable_io_port_bank.sv
`default_nettype none
module configurable_io_port_bank
	import io_port_pkg::*;
(
	// clock and reset
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// host register access
	input  wire io_port_pkg::host_req_t  hostReq,
	output var  logic [7:0]              hostRdata,
	output logic                         hostRvalid,
	// logic-array terms per port a..c, d in low bits
	input  wire logic [3:0][7:0]         arrayOe,
	input  wire logic [7:0]              groupOneCells,
	input  wire logic [7:0]              groupTwoCells,
	input  wire logic                    groupOneToB,
	input  wire logic                    groupTwoToC,
	input  wire logic [2:0]              csTerm,
	input  wire logic [2:0]              csActiveHigh,
	input  wire logic [3:0][7:0]         inputCellLatch,
	// latched address and data port
	input  wire logic [7:0]              latchedAddr,
	input  wire logic                    dataPortMode,
	input  wire logic [7:0]              dataPortOut,
	input  wire logic                    dataPortDrive,
	output var  logic [7:0]              dataPortIn,
	// pins: in, out, enable (enable low = drive)
	input  wire logic [3:0][7:0]         pinIn,
	output var  logic [3:0][7:0]         pinOut,
	output var  logic [3:0][7:0]         pinOen,
	output var  logic [3:0][7:0]         pinFast,
	// logic-array side
	output var  logic [3:0][7:0]         arrayInputBus,
	output logic                         memDisable
);
	logic [3:0][7:0] pinSync;
	logic [1:0][7:0] modeSel;
	logic [3:0][7:0] direction;
	logic [3:0][7:0] driveSel;
	logic [3:0][7:0] outValue;
	logic [2:0][7:0] cellValue;
	logic [2:0][7:0] cellMask;
	logic [2:0][7:0] inputCell;
	logic [3:0][7:0] driving;
	logic [3:0][7:0] srcValue;
	logic [2:0][7:0] cellToPin;
	logic [2:0][7:0] cellUse;
	logic [2:0]      csLevel;
	logic [1:0]      portIdx;
	logic            regWr;
	logic            regRd;
	pin_drive_t      drv [4];

	pin_sync #(
		.W(32)
	) u_pin_sync (
		.clk   (clk),
		.resetn(resetn),
		.raw   (pinIn),
		.sync  (pinSync)
	);

	// chip-select input gates the register block
	assign memDisable = pinSync[3][CS_IN_BIT];
	assign regWr = hostReq.wr && !memDisable;
	assign regRd = hostReq.rd && !memDisable;
	assign portIdx = hostReq.addr[1:0];

	// decoded write strobes
	logic wrMode;
	logic wrDir;
	logic wrDrive;
	logic wrOut;
	logic wrCell;
	logic wrMask;
	logic [7:0] regSel;
	assign regSel = {2'b00, hostReq.addr[7:2]} << 1;
	assign wrMode  = regWr && regSel == OFS_MODE_SELECT && !portIdx[1];
	assign wrDir   = regWr && regSel == OFS_DIRECTION;
	assign wrDrive = regWr && regSel == OFS_DRIVE_SELECT;
	assign wrOut   = regWr && regSel == OFS_OUTPUT_VALUE;
	assign wrCell  = regWr && regSel == OFS_CELL_VALUE && portIdx != PORT_D;
	assign wrMask  = regWr && regSel == OFS_CELL_MASK && portIdx != PORT_D;

	// mode select, ports a and b only
	always_ff @(posedge clk) begin
		if (!resetn) begin
			modeSel <= {2{RESET_CFG}};
		end else if (wrMode) begin
			modeSel[portIdx[0]] <= hostReq.wdata;
		end
	end

	// direction, port d keeps only three bits
	always_ff @(posedge clk) begin
		if (!resetn) begin
			direction <= {4{RESET_CFG}};
		end else if (wrDir) begin
			direction[portIdx] <= (portIdx == PORT_D) ?
				(hostReq.wdata & PORT_D_MASK) : hostReq.wdata;
		end
	end

	// drive select, unused bits of port d stay zero
	always_ff @(posedge clk) begin
		if (!resetn) begin
			driveSel <= {4{RESET_CFG}};
		end else if (wrDrive) begin
			driveSel[portIdx] <= (portIdx == PORT_D) ?
				(hostReq.wdata & SLEW_D) : hostReq.wdata;
		end
	end

	// output value register
	always_ff @(posedge clk) begin
		if (!resetn) begin
			outValue <= {4{RESET_CFG}};
		end else if (wrOut) begin
			outValue[portIdx] <= (portIdx == PORT_D) ?
				(hostReq.wdata & PORT_D_MASK) : hostReq.wdata;
		end
	end

	// output cells: host load gated by mask, else array value
	always_ff @(posedge clk) begin
		if (!resetn) begin
			cellValue <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				if (wrCell && portIdx == p[1:0]) begin
					cellValue[p] <= (hostReq.wdata & ~cellMask[p])
						| (cellValue[p] & cellMask[p]);
				end else begin
					cellValue[p] <= cellUse[p];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			cellMask <= {3{RESET_CFG}};
		end else if (wrMask) begin
			cellMask[portIdx] <= hostReq.wdata;
		end
	end

	// input cells capture pins where the array latch term allows
	always_ff @(posedge clk) begin
		if (!resetn) begin
			inputCell <= '0;
		end else begin
			for (int p = 0; p < 3; p++) begin
				inputCell[p] <= (pinSync[p] & inputCellLatch[p])
					| (inputCell[p] & ~inputCellLatch[p]);
			end
		end
	end

	// array input bus: input cells for a..c, port d pins direct
	always_comb begin
		arrayInputBus = '0;
		arrayInputBus[0] = inputCell[0];
		arrayInputBus[1] = inputCell[1];
		arrayInputBus[2] = inputCell[2];
		arrayInputBus[3] = pinSync[3] & PORT_D_MASK;
	end

	// cell routing: group one to a or b, group two to b or c
	always_comb begin
		cellUse[0] = groupOneToB ? '0 : groupOneCells;
		cellUse[1] = (groupOneToB ? groupOneCells : '0)
			| (groupTwoToC ? '0 : groupTwoCells);
		cellUse[2] = groupTwoToC ? groupTwoCells : '0;
		cellToPin = cellValue;
	end

	// chip-select outputs with selectable polarity
	assign csLevel = csTerm ~^ csActiveHigh;

	// pin value sources and enables
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			driving[p] = direction[p] | arrayOe[p];
			srcValue[p] = outValue[p];
		end
		driving[3] = (direction[3] | arrayOe[3]) & PORT_D_MASK;
		for (int p = 0; p < 2; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (modeSel[p][b]) begin
					srcValue[p][b] = latchedAddr[b];
				end else if (arrayOe[p][b]) begin
					srcValue[p][b] = cellToPin[p][b];
				end
			end
		end
		for (int b = 0; b < 8; b++) begin
			if (arrayOe[2][b]) begin
				srcValue[2][b] = cellToPin[2][b];
			end
		end
		for (int b = 0; b < 3; b++) begin
			if (arrayOe[3][b]) begin
				srcValue[3][b] = csLevel[b];
			end
		end
		srcValue[3] = srcValue[3] & PORT_D_MASK;
		if (dataPortMode) begin
			driving[0] = {8{dataPortDrive}};
			srcValue[0] = dataPortOut;
		end
	end

	// driver stage: open drain pins only pull low
	always_comb begin
		logic [7:0] od;
		od = '0;
		for (int p = 0; p < 4; p++) begin
			unique case (p)
				0, 1: od = driveSel[p] & OPEN_DRAIN_AB;
				2: od = driveSel[p] & OPEN_DRAIN_C;
				default: od = '0;
			endcase
			drv[p].out = srcValue[p] & ~od;
			drv[p].oen = ~(driving[p] & ~(od & srcValue[p]));
			unique case (p)
				0, 1: drv[p].fast = driveSel[p] & SLEW_AB;
				2: drv[p].fast = '0;
				default: drv[p].fast = driveSel[p] & SLEW_D;
			endcase
		end
	end

	// registered pins: new config shows one cycle after the write
	always_ff @(posedge clk) begin
		if (!resetn) begin
			pinOut  <= '0;
			pinOen  <= '1;
			pinFast <= '0;
		end else begin
			for (int p = 0; p < 4; p++) begin
				pinOut[p]  <= drv[p].out;
				pinOen[p]  <= drv[p].oen;
				pinFast[p] <= drv[p].fast;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!resetn) begin
			dataPortIn <= '0;
		end else begin
			dataPortIn <= pinSync[0];
		end
	end

	// register read data, one cycle after the read request
	always_ff @(posedge clk) begin
		if (!resetn) begin
			hostRdata  <= '0;
			hostRvalid <= 1'b0;
		end else begin
			hostRvalid <= regRd;
			hostRdata  <= '0;
			if (regRd) begin
				if (regSel == OFS_INPUT_SAMPLE) begin
					hostRdata <= pinSync[portIdx];
				end else if (regSel == OFS_MODE_SELECT && !portIdx[1]) begin
					hostRdata <= modeSel[portIdx[0]];
				end else if (regSel == OFS_OUTPUT_VALUE) begin
					hostRdata <= outValue[portIdx];
				end else if (regSel == OFS_DIRECTION) begin
					hostRdata <= direction[portIdx];
				end else if (regSel == OFS_DRIVE_SELECT) begin
					hostRdata <= driveSel[portIdx];
				end else if (portIdx != PORT_D) begin
					if (regSel == OFS_CELL_VALUE) begin
						hostRdata <= cellValue[portIdx];
					end else if (regSel == OFS_CELL_MASK) begin
						hostRdata <= cellMask[portIdx];
					end else if (regSel == OFS_INPUT_CELL) begin
						hostRdata <= inputCell[portIdx];
					end else if (regSel == OFS_DRIVE_STATUS) begin
						hostRdata <= ~drv[portIdx].oen;
					end
				end
			end
		end
	end

	// checks
	sequence s_dir_write;
		wrDir && portIdx == PORT_C && !arrayOe[2][0];
	endsequence
	sequence s_oe_quiet;
		arrayOe[2][0] == 1'b0;
	endsequence
	chk_dir_to_pin: assert property (
		@(posedge clk) disable iff (!resetn)
		s_dir_write ##1 s_oe_quiet
		|=> pinOen[2][0] == !(direction[2][0]
			&& !(driveSel[2][0] && outValue[2][0])))
		else $error("pin enable does not follow direction");
	chk_portd_dir: assert property (
		@(posedge clk) disable iff (!resetn)
		direction[3][7:3] == 5'h00)
		else $error("port d upper direction bits set");
	chk_mask_block: assert property (
		@(posedge clk) disable iff (!resetn)
		wrCell && cellMask[portIdx][0]
		|=> cellValue[$past(portIdx)][0]
			== $past(cellValue[portIdx][0]))
		else $error("masked cell was loaded");
	chk_cs_disable: assert property (
		@(posedge clk) disable iff (!resetn)
		memDisable && hostReq.rd |=> !hostRvalid)
		else $error("read answered while deselected");
	chk_read_answer: assert property (
		@(posedge clk) disable iff (!resetn)
		!memDisable && hostReq.rd |=> hostRvalid)
		else $error("selected read not answered");
	chk_read_out: assert property (
		@(posedge clk) disable iff (!resetn)
		regRd && regSel == OFS_OUTPUT_VALUE
		|=> hostRdata == $past(outValue[portIdx]))
		else $error("output value read back wrong");
	chk_mode_cd: assert property (
		@(posedge clk) disable iff (!resetn)
		regWr && regSel == OFS_MODE_SELECT && portIdx[1]
		|=> $stable(modeSel))
		else $error("mode register written for c or d");
	chk_slew_c: assert property (
		@(posedge clk) disable iff (!resetn)
		pinFast[2] == 8'h00)
		else $error("port c has slew control");
	chk_slew_d: assert property (
		@(posedge clk) disable iff (!resetn)
		pinFast[3][7:3] == 5'h00)
		else $error("port d upper slew bits set");
	chk_open_drain: assert property (
		@(posedge clk) disable iff (!resetn)
		driveSel[2][0] && outValue[2][0] && !arrayOe[2][0]
		|=> pinOen[2][0])
		else $error("open drain pin drives high");
	chk_pin_released: assert property (
		@(posedge clk) disable iff (!resetn)
		direction[1] == 8'h00 && arrayOe[1] == 8'h00
		|=> pinOen[1] == 8'hFF)
		else $error("port b drives without enable");
	chk_cs_level: assert property (
		@(posedge clk) disable iff (!resetn)
		arrayOe[3][0]
		|=> pinOut[3][0]
			== $past(csActiveHigh[0] ? csTerm[0] : !csTerm[0]))
		else $error("chip-select level has wrong polarity");
	chk_input_hold: assert property (
		@(posedge clk) disable iff (!resetn)
		!inputCellLatch[2][0] |=> $stable(inputCell[2][0]))
		else $error("input cell moved while not latching");
	chk_reset_cfg: assert property (
		@(posedge clk)
		!resetn |=> direction == '0 && driveSel == '0 && modeSel == '0)
		else $error("configuration not cleared by reset");
endmodule : configurable_io_port_bank
`default_nettype wire

// file: dv/pin_partner.sv
`default_nettype none
module pin_partner (
	// pad levels from the bank
	input  wire logic [3:0][7:0] pinOut,
	input  wire logic [3:0][7:0] pinOen,
	// levels driven by outside parts
	input  wire logic [3:0][7:0] extLevel,
	// resolved pad levels
	output var  logic [3:0][7:0] pinIn
);
	timeunit 1ns;
	timeprecision 1ps;
	// driven pins show the bank, released pins the outside part
	always_comb begin
		for (int p = 0; p < 4; p++) begin
			pinIn[p] = (pinOut[p] & ~pinOen[p]) | (extLevel[p] & pinOen[p]);
		end
	end
endmodule : pin_partner
`default_nettype wire

// file: dv/configurable_io_port_bank_tb_top.sv
`default_nettype none
module configurable_io_port_bank_tb_top import io_port_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic                clk;
	logic                resetn;
	host_req_t           hostReq;
	logic [7:0]          hostRdata;
	logic                hostRvalid;
	logic [3:0][7:0]     arrayOe;
	logic [3:0][7:0]     inputCellLatch;
	logic [3:0][7:0]     extLevel;
	logic [3:0][7:0]     pinIn;
	logic [3:0][7:0]     pinOut;
	logic [3:0][7:0]     pinOen;
	logic [3:0][7:0]     pinFast;
	logic [3:0][7:0]     arrayInputBus;
	logic [7:0]          groupOneCells;
	logic [7:0]          latchedAddr;
	logic [7:0]          dataPortOut;
	logic [7:0]          dataPortIn;
	logic                dataPortMode;
	logic                dataPortDrive;
	logic                memDisable;
	logic [7:0]          groupTwoCells;
	logic                groupOneToB;
	logic                groupTwoToC;
	logic [2:0]          csTerm;
	logic [2:0]          csActiveHigh;
	int                  mismatches;
	int                  comparisons;
	configurable_io_port_bank uut (
		.clk(clk), .resetn(resetn), .hostReq(hostReq),
		.hostRdata(hostRdata), .hostRvalid(hostRvalid), .arrayOe(arrayOe),
		.groupOneCells(groupOneCells), .groupTwoCells(groupTwoCells),
		.groupOneToB(groupOneToB), .groupTwoToC(groupTwoToC),
		.csTerm(csTerm), .csActiveHigh(csActiveHigh),
		.inputCellLatch(inputCellLatch),
		.latchedAddr(latchedAddr), .dataPortMode(dataPortMode),
		.dataPortOut(dataPortOut), .dataPortDrive(dataPortDrive),
		.dataPortIn(dataPortIn), .pinIn(pinIn), .pinOut(pinOut),
		.pinOen(pinOen), .pinFast(pinFast), .arrayInputBus(arrayInputBus),
		.memDisable(memDisable));
	pin_partner far_side (
		.pinOut(pinOut), .pinOen(pinOen), .extLevel(extLevel), .pinIn(pinIn));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", comparisons, mismatches);
		if (mismatches == 0 && comparisons > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic check8(input string what, input logic [7:0] exp, got);
		comparisons++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check8
	function automatic logic [7:0] ra(input logic [7:0] o, input port_sel_t p);
		return {o[6:0], 1'h0} | {6'h00, p};
	endfunction : ra
	// host write cycle, strobe for one edge
	task automatic wr(input logic [7:0] o, input port_sel_t p, logic [7:0] d);
		@(posedge clk);
		hostReq <= '{rd: 1'h0, wr: 1'h1, addr: ra(o, p), wdata: d};
		@(posedge clk);
		hostReq <= '0;
	endtask : wr
	// host read cycle, data taken with the valid pulse
	task automatic rdChk(input string what, input logic [7:0] o,
			input port_sel_t p, input logic [7:0] exp);
		@(posedge clk);
		hostReq <= '{rd: 1'h1, wr: 1'h0, addr: ra(o, p), wdata: 8'h00};
		@(posedge clk);
		hostReq <= '0;
		for (int i = 0; i < 8; i++) begin
			#1;
			if (hostRvalid === 1'h1) begin
				check8(what, exp, hostRdata);
				return;
			end
			@(posedge clk);
		end
		mismatches++;
		tally_and_finish();
	endtask : rdChk
	task automatic settle();
		repeat (4) @(posedge clk);
		#1;
	endtask : settle
	task automatic waitDisable(input logic lvl);
		for (int i = 0; i < 16; i++) begin
			@(posedge clk);
			#1;
			if (memDisable === lvl) begin
				return;
			end
		end
		mismatches++;
		tally_and_finish();
	endtask : waitDisable
	task automatic test_reset();
		for (int p = 0; p < 4; p++) begin
			rdChk("dir", OFS_DIRECTION, port_sel_t'(p), 8'h00);
			rdChk("drive", OFS_DRIVE_SELECT, port_sel_t'(p), 8'h00);
			check8("oen", 8'hFF, pinOen[p]);
		end
		rdChk("mode a", OFS_MODE_SELECT, PORT_A, 8'h00);
		rdChk("mode b", OFS_MODE_SELECT, PORT_B, 8'h00);
		rdChk("mask a", OFS_CELL_MASK, PORT_A, 8'h00);
		$display("test reset done");
	endtask : test_reset
	task automatic test_direction();
		wr(OFS_OUTPUT_VALUE, PORT_A, 8'hA5);
		wr(OFS_DIRECTION, PORT_A, 8'h0F);
		settle();
		check8("oen a", 8'hF0, pinOen[0]);
		check8("out a", 8'h05, {4'h0, pinOut[0][3:0]});
		rdChk("outval a", OFS_OUTPUT_VALUE, PORT_A, 8'hA5);
		rdChk("status a", OFS_DRIVE_STATUS, PORT_A, 8'h0F);
		$display("test direction done");
	endtask : test_direction
	task automatic test_array_oe();
		wr(OFS_OUTPUT_VALUE, PORT_B, 8'hFF);
		arrayOe[1] <= 8'h81;
		settle();
		check8("oen b", 8'h7E, pinOen[1]);
		rdChk("status b", OFS_DRIVE_STATUS, PORT_B, 8'h81);
		@(posedge clk);
		arrayOe[1] <= 8'h00;
		wr(OFS_DIRECTION, PORT_D, 8'hFF);
		settle();
		check8("oen d", 8'hF8, pinOen[3]);
		wr(OFS_DIRECTION, PORT_D, 8'h00);
		arrayOe[3] <= 8'h07;
		csTerm <= 3'h5;
		csActiveHigh <= 3'h3;
		settle();
		check8("cs out", 8'h01, pinOut[3]);
		check8("cs oen", 8'hF8, pinOen[3]);
		@(posedge clk);
		arrayOe[3] <= 8'h00;
		$display("test array_oe done");
	endtask : test_array_oe
	task automatic test_drive();
		wr(OFS_DRIVE_SELECT, PORT_A, 8'hFF);
		wr(OFS_DIRECTION, PORT_A, 8'hFF);
		wr(OFS_OUTPUT_VALUE, PORT_C, 8'h0F);
		wr(OFS_DRIVE_SELECT, PORT_C, 8'hFF);
		wr(OFS_DIRECTION, PORT_C, 8'hFF);
		wr(OFS_DRIVE_SELECT, PORT_D, 8'hFF);
		settle();
		check8("fast a", 8'h0F, pinFast[0]);
		check8("fast c", 8'h00, pinFast[2]);
		check8("fast d", 8'h07, {5'h00, pinFast[3][2:0]});
		check8("oen c", 8'h0F, pinOen[2]);
		check8("out c", 8'h00, pinOut[2]);
		wr(OFS_DRIVE_SELECT, PORT_A, 8'h00);
		wr(OFS_OUTPUT_VALUE, PORT_A, 8'hF0);
		settle();
		check8("oen pp", 8'h00, pinOen[0]);
		check8("out pp", 8'hF0, pinOut[0]);
		$display("test drive done");
	endtask : test_drive
	task automatic test_mode();
		@(posedge clk);
		latchedAddr <= 8'hC3;
		wr(OFS_MODE_SELECT, PORT_A, 8'hFF);
		settle();
		check8("addr out", 8'hC3, pinOut[0]);
		rdChk("mode a", OFS_MODE_SELECT, PORT_A, 8'hFF);
		wr(OFS_MODE_SELECT, PORT_A, 8'h00);
		settle();
		check8("io out", 8'hF0, pinOut[0]);
		wr(OFS_MODE_SELECT, PORT_C, 8'hFF);
		rdChk("mode a kept", OFS_MODE_SELECT, PORT_A, 8'h00);
		rdChk("mode c", OFS_MODE_SELECT, PORT_C, 8'h00);
		$display("test mode done");
	endtask : test_mode
	task automatic test_inputs();
		wr(OFS_DIRECTION, PORT_C, 8'h00);
		wr(OFS_DIRECTION, PORT_A, 8'h00);
		extLevel[2] <= 8'h5A;
		extLevel[0] <= 8'h3C;
		inputCellLatch[2] <= 8'hFF;
		groupOneCells <= 8'h5C;
		groupTwoCells <= 8'h3A;
		groupOneToB <= 1'h1;
		groupTwoToC <= 1'h1;
		settle();
		rdChk("in c", OFS_INPUT_SAMPLE, PORT_C, 8'h5A);
		rdChk("in a", OFS_INPUT_SAMPLE, PORT_A, 8'h3C);
		rdChk("cell in c", OFS_INPUT_CELL, PORT_C, 8'h5A);
		check8("array bus c", 8'h5A, arrayInputBus[2]);
		wr(OFS_CELL_MASK, PORT_A, 8'hF1);
		rdChk("mask a", OFS_CELL_MASK, PORT_A, 8'hF1);
		wr(OFS_CELL_VALUE, PORT_A, 8'hFF);
		rdChk("cell a", OFS_CELL_VALUE, PORT_A, 8'h00);
		rdChk("cell b", OFS_CELL_VALUE, PORT_B, 8'h5C);
		rdChk("cell c", OFS_CELL_VALUE, PORT_C, 8'h3A);
		$display("test inputs done");
	endtask : test_inputs
	task automatic test_data_port();
		@(posedge clk);
		dataPortMode <= 1'h1;
		dataPortDrive <= 1'h1;
		dataPortOut <= 8'h96;
		settle();
		check8("data out", 8'h96, pinOut[0]);
		check8("data oen", 8'h00, pinOen[0]);
		@(posedge clk);
		dataPortDrive <= 1'h0;
		settle();
		check8("data in", 8'h3C, dataPortIn);
		@(posedge clk);
		dataPortMode <= 1'h0;
		$display("test data_port done");
	endtask : test_data_port
	task automatic test_disable();
		@(posedge clk);
		extLevel[3][2] <= 1'h1;
		waitDisable(1'h1);
		wr(OFS_DIRECTION, PORT_C, 8'hFF);
		@(posedge clk);
		hostReq <= '{rd: 1'h1, wr: 1'h0, addr: ra(OFS_DIRECTION, PORT_C),
			wdata: 8'h00};
		@(posedge clk);
		hostReq <= '0;
		repeat (2) begin
			@(posedge clk);
			#1;
			check8("valid off", 8'h00, {7'h00, hostRvalid});
		end
		@(posedge clk);
		extLevel[3][2] <= 1'h0;
		waitDisable(1'h0);
		rdChk("dir c", OFS_DIRECTION, PORT_C, 8'h00);
		$display("test disable done");
	endtask : test_disable
	initial begin
		mismatches = 0;
		comparisons = 0;
		resetn = 1'h0;
		hostReq = '0;
		arrayOe = '0;
		inputCellLatch = '0;
		extLevel = '0;
		groupOneCells = 8'h00;
		groupTwoCells = 8'h00;
		groupOneToB = 1'h0;
		groupTwoToC = 1'h0;
		csTerm = 3'h0;
		csActiveHigh = 3'h0;
		latchedAddr = 8'h00;
		dataPortOut = 8'h00;
		dataPortMode = 1'h0;
		dataPortDrive = 1'h0;
		repeat (3) @(posedge clk);
		resetn <= 1'h1;
		test_reset();
		test_direction();
		test_array_oe();
		test_drive();
		test_mode();
		test_inputs();
		test_data_port();
		test_disable();
		tally_and_finish();
	end
endmodule : configurable_io_port_bank_tb_top
`default_nettype wire
